// File: logic/mem_port_pkg.sv
// constants, state codes and carrier types for the external memory bus port
// assumes one system clock; every pin input is sampled through two flip-flops
package mem_port_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 32;            // address pins
    localparam int DATA_W = 32;            // data pins
    localparam int SYNC_W = 40;            // all sampled pin inputs

    // ==========================================================
    // bit positions inside the sampled pin vector
    localparam int SY_MCLK  = 0;           // memory clock
    localparam int SY_ABE   = 1;           // addr_drive_enable
    localparam int SY_DBE   = 2;           // data_drive_enable
    localparam int SY_MSE   = 3;           // request_seq_drive_enable
    localparam int SY_ALE   = 4;           // address latch enable
    localparam int SY_ABORT = 5;           // abort from memory
    localparam int SY_WAIT  = 6;           // wait_n
    localparam int SY_FIQ   = 7;           // fast_irq_n
    localparam int SY_DATA  = 8;           // data bus low bit

    // ==========================================================
    // values after reset, and the buffer full count
    localparam logic [39:0] SYNC_RST = 40'h00_0000_00c0;  // wait_n and fast_irq_n idle high
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;     // address after reset
    localparam logic [31:0] DATA_RST = 32'h0000_0000;     // write data after reset
    localparam logic        MREQ_RST = 1'b1;              // no memory request
    localparam logic [1:0]  CNT_RST  = 2'h0;              // buffer empty
    localparam logic [1:0]  BUF_FULL = 2'h2;              // two-entry buffer

    // ==========================================================
    // access sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,               // waiting for a core request
        ST_ANNOUNCE = 5'h02,               // waiting for mclk fall to request
        ST_ADDR     = 5'h04,               // waiting for mclk rise to drive address
        ST_ACCESS   = 5'h08,               // waiting for mclk fall to sample
        ST_WDRIVE   = 5'h10                // write data held until mclk rise
    } bus_state_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [31:0] addr;                 // byte address
        logic        write;                // 1 = write
        logic        word;                 // 1 = word, 0 = byte
        logic        lock;                 // part of a locked sequence
        logic [31:0] wdata;                // write data
    } core_req_t;

    typedef struct packed {
        logic [31:0] rdata;                // read data, zero for writes
        logic        write;                // answer belongs to a write
        logic        abort;                // memory reported failure
    } core_resp_t;

    typedef struct packed {
        logic [31:0] addr;                 // address pins
        logic        write;                // read_write_n
        logic        word;                 // byte_word_n
        logic        lock;                 // lock output
    } addr_phase_t;

endpackage

// File: logic/mem_bus_port.sv
// external memory bus port: core requests in, memory clock timed pin cycles out
// assumes clk_sys is the fast core clock; mclk and all pins are asynchronous
`timescale 1ns/10ps

// Functional notes
// RULE1 - address, direction, width, lock float when disabled
// RULE2 - data drivers float except writes, or disabled
// RULE3 - systems without sharing hold data enable high
// RULE4 - request and sequential float when enable low
// RULE5 - address group through transparent latch on ale
// RULE6 - address presented, changing in mclk high
// RULE7 - read data captured at mclk falling edge
// RULE8 - write data driven in mclk low phase
// RULE9 - byte_word_n high word, changes mclk high
// RULE10 - lock raised in high phase, held through sequence
// RULE11 - manager grants nobody else while lock high
// RULE12 - abort sampled only during external accesses
// RULE13 - core clock internal, memory clock times accesses
// RULE14 - memory clock may stretch, or wait used
// RULE15 - low fast_irq_n with enable raises fast interrupt
// RULE16 - source holds fast_irq_n low until answered
// RULE17 - read_write_n high write, changes mclk high
// RULE18 - request low in low phase, sequential inverse
// RULE19 - wait_n low extends access, changes low phase
// RULE20 - fast_irq_n synchronised before use
module mem_bus_port (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    // core request side
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire mem_port_pkg::core_req_t req,
    // core answer side
    output logic                        resp_valid,
    input  wire logic                   resp_ready,
    output mem_port_pkg::core_resp_t    resp,
    // fast interrupt
    input  wire logic                   fiq_enable,
    input  wire logic                   fast_irq_n,
    output logic                        fast_interrupt,
    // memory clock and pin controls
    input  wire logic                   mclk,
    input  wire logic                   addr_drive_enable,
    input  wire logic                   data_drive_enable,
    input  wire logic                   request_seq_drive_enable,
    input  wire logic                   addr_latch_enable,
    input  wire logic                   abort_in,
    input  wire logic                   wait_n,
    // address group
    output logic [31:0]                 mem_addr,
    output logic                        read_write_n,
    output logic                        byte_word_n,
    output logic                        lock_out,
    output logic                        addr_oe,
    // data bus
    input  wire logic [31:0]            data_in,
    output logic [31:0]                 data_out,
    output logic                        data_oe,
    // request and sequential
    output logic                        mem_request_n,
    output logic                        sequential_addr,
    output logic                        request_seq_oe
);

    // ==========================================================
    // pin sampling
    logic [39:0]                sync1;          // first stage, read only by sync2
    logic [39:0]                sync2;          // second stage, safe to use
    logic                       mclk_d;         // previous sampled mclk
    logic                       mclk_rise;      // one-cycle enable at mclk rise
    logic                       mclk_fall;      // one-cycle enable at mclk fall
    logic                       abe_s;          // sampled address enable
    logic                       dbe_s;          // sampled data enable
    logic                       mse_s;          // sampled request enable
    logic                       ale_s;          // sampled latch enable
    logic                       abort_s;        // sampled abort
    logic                       wait_s;         // sampled wait_n
    logic                       fiq_s;          // sampled fast_irq_n
    logic [31:0]                din_s;          // sampled data bus

    // both stages reset to idle pin levels so no false wait or interrupt
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync1 <= mem_port_pkg::SYNC_RST;
            sync2 <= mem_port_pkg::SYNC_RST;
        end else begin
            sync1 <= {data_in, fast_irq_n, wait_n, abort_in, addr_latch_enable,
                      request_seq_drive_enable, data_drive_enable, addr_drive_enable, mclk};
            sync2 <= sync1;                                             // RULE20
        end
    end

    assign abe_s   = sync2[mem_port_pkg::SY_ABE];
    assign dbe_s   = sync2[mem_port_pkg::SY_DBE];
    assign mse_s   = sync2[mem_port_pkg::SY_MSE];
    assign ale_s   = sync2[mem_port_pkg::SY_ALE];
    assign abort_s = sync2[mem_port_pkg::SY_ABORT];
    assign wait_s  = sync2[mem_port_pkg::SY_WAIT];
    assign fiq_s   = sync2[mem_port_pkg::SY_FIQ];
    assign din_s   = sync2[mem_port_pkg::SY_DATA +: 32];

    // memory clock edges; stretched phases simply delay the next enable
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mclk_d <= 1'b0;
        end else begin
            mclk_d <= sync2[mem_port_pkg::SY_MCLK];
        end
    end

    assign mclk_rise = sync2[mem_port_pkg::SY_MCLK] & ~mclk_d;      // RULE13 RULE14
    assign mclk_fall = ~sync2[mem_port_pkg::SY_MCLK] & mclk_d;      // RULE13 RULE14

    // ==========================================================
    // access sequencer
    mem_port_pkg::bus_state_t   state;          // current step of the access
    mem_port_pkg::core_req_t    cur;            // request being served
    mem_port_pkg::addr_phase_t  addr_int;       // address group before the latch
    mem_port_pkg::addr_phase_t  addr_hold;      // value held while ale low
    mem_port_pkg::addr_phase_t  addr_pin;       // latch output
    logic                       mreq;           // pipelined request, low active
    logic                       wdrive;         // write data phase active
    logic                       push;           // answer ready for the buffer
    logic                       done_rd;        // read finishes this cycle
    logic                       done_wr;        // write finishes this cycle
    mem_port_pkg::core_resp_t   push_data;      // answer going into the buffer
    logic                       abort_cap;      // abort seen in this access
    logic [1:0]                 cnt;            // buffer occupancy

    // a new access is taken only while the buffer can hold its answer
    assign req_ready = (state == mem_port_pkg::ST_IDLE) && (cnt != mem_port_pkg::BUF_FULL);
    // wait_n low at the fall stretches the access by a whole mclk cycle
    assign done_rd   = (state == mem_port_pkg::ST_ACCESS) && mclk_fall && wait_s && !cur.write;   // RULE7
    assign done_wr   = (state == mem_port_pkg::ST_WDRIVE) && mclk_rise;
    assign push      = done_rd || done_wr;

    // state steps after ST_IDLE, each waiting for its memory clock edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= mem_port_pkg::ST_IDLE;
        end else begin
            case (state)
                mem_port_pkg::ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        state <= mem_port_pkg::ST_ANNOUNCE;
                    end
                end
                mem_port_pkg::ST_ANNOUNCE: begin
                    if (mclk_fall) begin
                        state <= mem_port_pkg::ST_ADDR;
                    end
                end
                mem_port_pkg::ST_ADDR: begin
                    if (mclk_rise) begin
                        state <= mem_port_pkg::ST_ACCESS;
                    end
                end
                mem_port_pkg::ST_ACCESS: begin
                    if (mclk_fall && wait_s) begin                      // RULE19
                        state <= cur.write ? mem_port_pkg::ST_WDRIVE : mem_port_pkg::ST_IDLE;
                    end
                end
                mem_port_pkg::ST_WDRIVE: begin
                    if (mclk_rise) begin
                        state <= mem_port_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= mem_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // request capture
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cur <= '0;
        end else if (req_valid && req_ready) begin
            cur <= req;
        end
    end

    // address group changes only on an mclk rise
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addr_int <= {mem_port_pkg::ADDR_RST, 3'h0};
        end else if (mclk_rise && state == mem_port_pkg::ST_ADDR) begin
            addr_int <= {cur.addr, cur.write, cur.word, cur.lock};     // RULE6 RULE9 RULE10 RULE17
        end else if (mclk_rise && state == mem_port_pkg::ST_IDLE && !req_valid) begin
            addr_int.lock <= 1'b0;                                      // RULE10
        end
    end

    // transparent latch: follows while ale high, holds while low
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addr_hold <= {mem_port_pkg::ADDR_RST, 3'h0};
        end else if (ale_s) begin
            addr_hold <= addr_int;                                      // RULE5
        end
    end

    assign addr_pin     = ale_s ? addr_int : addr_hold;                 // RULE5
    assign mem_addr     = addr_pin.addr;
    assign read_write_n = addr_pin.write;
    assign byte_word_n  = addr_pin.word;
    assign lock_out     = addr_pin.lock;
    assign addr_oe      = abe_s;                                        // RULE1

    // pipelined request, changed only on an mclk fall
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mreq <= mem_port_pkg::MREQ_RST;
        end else if (mclk_fall && state == mem_port_pkg::ST_ANNOUNCE) begin
            mreq <= 1'b0;                                               // RULE18
        end else if (mclk_fall && state == mem_port_pkg::ST_ACCESS && wait_s) begin
            mreq <= 1'b1;                                               // RULE18
        end
    end

    assign mem_request_n   = mreq;
    assign sequential_addr = ~mreq;                                     // RULE18
    assign request_seq_oe  = mse_s;                                     // RULE4

    // write data drive from the low phase until the closing rise
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wdrive   <= 1'b0;
            data_out <= mem_port_pkg::DATA_RST;
        end else if (mclk_fall && state == mem_port_pkg::ST_ACCESS && cur.write) begin
            wdrive   <= 1'b1;                                           // RULE8
            data_out <= cur.wdata;
        end else if (done_wr) begin
            wdrive   <= 1'b0;
        end
    end

    // a system without bus sharing keeps data_drive_enable high
    assign data_oe = wdrive & dbe_s;                                    // RULE2 RULE3

    // abort looked at only on the sampling fall of an access
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            abort_cap <= 1'b0;
        end else if (mclk_fall && state == mem_port_pkg::ST_ACCESS) begin
            abort_cap <= abort_s;                                       // RULE12
        end
    end

    always_comb begin
        push_data.rdata = cur.write ? mem_port_pkg::DATA_RST : din_s;   // RULE7
        push_data.write = cur.write;
        push_data.abort = cur.write ? abort_cap : abort_s;             // RULE12
    end

    // ==========================================================
    // two-entry answer buffer; occupancy gates req_ready
    mem_port_pkg::core_resp_t   buf_mem [2];    // entries
    logic                       wp;             // write pointer
    logic                       rp;             // read pointer
    logic                       pop;            // answer taken by the core

    assign pop        = resp_valid && resp_ready;
    assign resp_valid = (cnt != mem_port_pkg::CNT_RST);
    assign resp       = buf_mem[rp];

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= mem_port_pkg::CNT_RST;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (push) begin
                buf_mem[wp] <= push_data;
                wp          <= ~wp;
            end
            if (pop) begin
                rp <= ~rp;
            end
            cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
        end
    end

    // ==========================================================
    // fast interrupt: level, only while enabled
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            fast_interrupt <= 1'b0;
        end else begin
            fast_interrupt <= fiq_enable & ~fiq_s;                      // RULE15 RULE16
        end
    end

    // ==========================================================
    // checks
    sequence s_read_fall;
        (state == mem_port_pkg::ST_ACCESS) && mclk_fall && wait_s && !cur.write;
    endsequence

    sequence s_write_fall;
        (state == mem_port_pkg::ST_ACCESS) && mclk_fall && cur.write;
    endsequence

    addr_float_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
        $fell(sync2[mem_port_pkg::SY_ABE]) |-> !addr_oe)
        else $error("address group driven while disabled");

    data_float_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE2
        data_oe |-> dbe_s && cur.write && (state inside {mem_port_pkg::ST_ACCESS, mem_port_pkg::ST_WDRIVE}))
        else $error("data bus driven outside a write");

    req_float_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
        !mse_s |-> !request_seq_oe)
        else $error("request driven while disabled");

    latch_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
        !ale_s && $past(!ale_s) |-> $stable(mem_addr) && $stable(lock_out))
        else $error("address latch not holding");

    addr_change_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE6
        $changed(addr_int.addr) |-> $past(mclk_rise))
        else $error("address changed away from mclk rise");

    read_push_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
        s_read_fall ##0 (!pop) |=> cnt == $past(cnt) + 2'h1)
        else $error("read data not captured at fall");

    write_drive_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE8
        s_write_fall |=> wdrive ##1 (wdrive || $past(done_wr)))
        else $error("write data not driven in low phase");

    width_dir_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9 RULE17
        $changed(addr_int.word) || $changed(addr_int.write) |-> $past(mclk_rise))
        else $error("width or direction changed off mclk rise");

    lock_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE10
        $changed(addr_int.lock) |-> $past(mclk_rise))
        else $error("lock changed off mclk rise");

    abort_win_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE12
        $changed(abort_cap) |-> $past(state == mem_port_pkg::ST_ACCESS && mclk_fall))
        else $error("abort sampled outside an access");

    mreq_phase_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE18
        $changed(mem_request_n) |-> $past(mclk_fall) && (sequential_addr == !mem_request_n))
        else $error("request changed off mclk fall");

    fiq_take_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE15 RULE20
        fiq_enable && !fast_irq_n ##1 fiq_enable && !fast_irq_n ##1 fiq_enable && !fast_irq_n
        |=> fast_interrupt)
        else $error("fast interrupt not raised");

endmodule // mem_bus_port

// File: verification/mem_system_model.sv
// memory system model: free memory clock, word store, wait and abort
// assumes pins come straight from the port; drive enables are not modelled
`timescale 1ns/10ps
module mem_system_model (
    // clocks
    input  wire logic        clk_sys,
    output logic             mclk,
    // pins from the port
    input  wire logic [31:0] mem_addr,
    input  wire logic        read_write_n,
    input  wire logic        byte_word_n,
    input  wire logic        lock_out,
    input  wire logic        mem_request_n,
    input  wire logic [31:0] data_out,
    input  wire logic        data_oe,
    // pins to the port
    output logic [31:0]      data_in,
    output logic             wait_n,
    output logic             abort_in,
    // scenario knobs
    input  wire logic [1:0]  stall,
    input  wire logic        fail
);
    logic [31:0] mem [16];   // word store, address bits 5:2 index it
    logic [34:0] seen;       // addr, rw, bw, lock at the access fall
    // ==========================================================
    // free running memory clock and store contents
    initial begin
        mclk = 1'b0;
        wait_n = 1'b1;
        for (int i = 0; i < 16; i++) mem[i] = 32'h5a5a_0000 | 32'(i);
    end
    always #160 mclk = ~mclk;
    // a write turn shows the inverse of the bus, never a stale copy
    assign data_in = read_write_n ? ~data_out : mem[mem_addr[5:2]];
    // failure only reported during an access
    assign abort_in = fail & ~mem_request_n;
    // wait low from the announce low phase, back high in a later low phase
    always @(negedge mem_request_n) begin
        if (stall != 2'h0) begin
            wait_n = 1'b0;
            repeat (stall) @(negedge mclk);
            #80 wait_n = 1'b1;
        end
    end
    // writes land while the port drives data
    always @(posedge clk_sys) begin
        if (data_oe) mem[mem_addr[5:2]] <= data_out;
    end
    // pin record per access; no other master exists to be granted
    always @(negedge mclk) begin
        if (!mem_request_n) seen <= {mem_addr, read_write_n, byte_word_n, lock_out};
    end
endmodule // mem_system_model

// File: verification/tb_top.sv
// bench for the memory bus port: core requests against the memory model
// assumes the timing assertions live inside the design files
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys, reset_n, req_valid, req_ready, resp_valid, resp_ready;
    logic        fiq_enable, fast_irq_n, fast_interrupt, mclk, wait_n, abort_in, fail, oe_seen;
    logic        addr_drive_enable, data_drive_enable, request_seq_drive_enable, addr_latch_enable;
    logic        read_write_n, byte_word_n, lock_out, addr_oe, data_oe;
    logic        mem_request_n, sequential_addr, request_seq_oe;
    logic [31:0] mem_addr, data_in, data_out;
    logic [1:0]  stall;
    mem_port_pkg::core_req_t  req;
    mem_port_pkg::core_resp_t resp;
    int          n_errors, checks, cycles;
    // ==========================================================
    // design and far side
    mem_bus_port uut (.clk_sys, .reset_n, .req_valid, .req_ready, .req, .resp_valid, .resp_ready, .resp,
        .fiq_enable, .fast_irq_n, .fast_interrupt, .mclk, .addr_drive_enable, .data_drive_enable,
        .request_seq_drive_enable, .addr_latch_enable, .abort_in, .wait_n, .mem_addr, .read_write_n,
        .byte_word_n, .lock_out, .addr_oe, .data_in, .data_out, .data_oe, .mem_request_n,
        .sequential_addr, .request_seq_oe);
    mem_system_model mdl (.clk_sys, .mclk, .mem_addr, .read_write_n, .byte_word_n, .lock_out,
        .mem_request_n, .data_out, .data_oe, .data_in, .wait_n, .abort_in, .stall, .fail);
    // clock, hang limit, sticky data drive flag, sequential watch
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (data_oe) oe_seen <= 1'b1;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    always @(negedge clk_sys) begin
        if (reset_n && request_seq_oe) check(40'(sequential_addr), 40'(!mem_request_n));
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // request held from a falling edge until the rising edge that takes it
    task automatic send(input logic [31:0] a, input logic w, wd, lk, input logic [31:0] d);
        req = '{a, w, wd, lk, d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask
    task automatic take(input logic [31:0] rd, input logic w, ab);
        resp_ready = 1'b1;
        while (resp_valid !== 1'b1) @(negedge clk_sys);
        check(40'({resp.rdata, resp.write, resp.abort}), 40'({rd, w, ab}));
        @(negedge clk_sys);
        resp_ready = 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_write_read();
        oe_seen = 1'b0;
        send(32'h10, 1'b1, 1'b1, 1'b0, 32'hcafe_0123);
        take(32'h0, 1'b1, 1'b0);
        check(40'({oe_seen, mdl.mem[4], mdl.seen[2:1]}), 40'h7_2bf8_048f);
        oe_seen = 1'b0;
        send(32'h10, 1'b0, 1'b1, 1'b0, 32'h0);
        take(32'hcafe_0123, 1'b0, 1'b0);
        check(40'({oe_seen, mdl.seen}), {4'h0, 1'b0, 32'h10, 3'h2});
    endtask
    task automatic t_byte_wait_abort();
        stall = 2'h1;
        send(32'h23, 1'b0, 1'b0, 1'b0, 32'h0);
        take(32'h5a5a_0008, 1'b0, 1'b0);
        check(40'(mdl.seen), {5'h0, 32'h23, 3'h0});
        {stall, fail} = 3'h1;
        send(32'h28, 1'b1, 1'b1, 1'b0, 32'h1);
        take(32'h0, 1'b1, 1'b1);
        fail = 1'b0;
        send(32'h04, 1'b0, 1'b1, 1'b0, 32'h0);
        take(32'h5a5a_0001, 1'b0, 1'b0);
    endtask
    task automatic t_lock_latch();
        send(32'h08, 1'b0, 1'b1, 1'b1, 32'h0);
        take(32'h5a5a_0002, 1'b0, 1'b0);
        check(40'({mdl.seen[0], lock_out}), 40'h3);
        send(32'h0c, 1'b0, 1'b1, 1'b0, 32'h0);
        take(32'h5a5a_0003, 1'b0, 1'b0);
        repeat (24) @(negedge clk_sys);
        check(40'(lock_out), 40'h0);
        addr_latch_enable = 1'b0;
        repeat (4) @(negedge clk_sys);
        send(32'h30, 1'b0, 1'b1, 1'b0, 32'h0);
        take(32'h5a5a_0003, 1'b0, 1'b0);
        check(40'(mem_addr), 40'hc);
        addr_latch_enable = 1'b1;
        repeat (24) @(negedge clk_sys);
        check(40'(mem_addr), 40'h30);
    endtask
    task automatic t_enables();
        oe_seen = 1'b0;
        {addr_drive_enable, data_drive_enable, request_seq_drive_enable} = 3'h0;
        repeat (4) @(negedge clk_sys);
        check(40'({addr_oe, request_seq_oe}), 40'h0);
        send(32'h3c, 1'b1, 1'b1, 1'b0, 32'h1234_5678);
        take(32'h0, 1'b1, 1'b0);
        check(40'({oe_seen, mdl.mem[15]}), 40'h5a5a_000f);
        {addr_drive_enable, data_drive_enable, request_seq_drive_enable} = 3'h7;
        repeat (4) @(negedge clk_sys);
        check(40'({addr_oe, request_seq_oe}), 40'h3);
    endtask
    // two answers left waiting must refuse a third request
    task automatic t_buffer();
        send(32'h0, 1'b0, 1'b1, 1'b0, 32'h0);
        @(negedge clk_sys);
        send(32'h4, 1'b0, 1'b1, 1'b0, 32'h0);
        repeat (100) @(negedge clk_sys);
        check(40'({req_ready, resp_valid}), 40'h1);
        take(32'h5a5a_0000, 1'b0, 1'b0);
        @(negedge clk_sys);
        take(32'h5a5a_0001, 1'b0, 1'b0);
        check(40'(resp_valid), 40'h0);
    endtask
    task automatic t_fiq();
        {fiq_enable, fast_irq_n} = 2'h2;
        @(negedge clk_sys);
        check(40'(fast_interrupt), 40'h0);
        repeat (4) @(negedge clk_sys);
        check(40'(fast_interrupt), 40'h1);
        {fiq_enable, fast_irq_n} = 2'h1;
        repeat (2) @(negedge clk_sys);
        fast_irq_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        check(40'(fast_interrupt), 40'h0);
        fast_irq_n = 1'b1;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {reset_n, req_valid, resp_ready, fiq_enable, stall, fail, oe_seen} = 8'h0;
        {fast_irq_n, addr_drive_enable, data_drive_enable, request_seq_drive_enable} = 4'hf;
        addr_latch_enable = 1'b1;
        req = '0;
        repeat (8) @(negedge clk_sys);
        check(40'({req_ready, resp_valid, mem_request_n, data_oe, lock_out, fast_interrupt}), 40'h28);
        reset_n = 1'b1;
        t_write_read();
        t_byte_wait_abort();
        t_lock_latch();
        t_enables();
        t_buffer();
        t_fiq();
        stop_test();
    end
endmodule // tb_top
